// ===== design/flash_self_program_ctrl.sv
`timescale 1ns/1ns
module flash_self_program_ctrl
	import flash_self_program_pkg::*;
#(
	parameter int unsigned OP_CYCLES_P = OP_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic [15:0] i_addr,
	input wire logic [15:0] i_wr_data,
	input wire logic i_wr_stb,
	input wire logic i_rd_stb,
	output logic [15:0] o_rd_data,
	input wire table_req_t i_tbl,
	output logic o_tbl_ack,
	output logic [15:0] o_tbl_rdata,
	output flash_cmd_t o_flash,
	input wire logic [23:0] i_flash_rdata,
	input wire logic i_master_clear_pin_evt,
	input wire logic i_wdt_evt,
	input wire logic i_done_clr,
	output logic o_done_flag,
	output logic o_cpu_stall
);

	// ==========================================================
	// Declarations
	logic [15:0] ctrl_reg, ctrl_next;
	logic [15:0] adrl_reg, adrl_next;
	logic [7:0] adru_reg, adru_next;
	logic [7:0] page_reg, page_next;
	key_state_t key_reg, key_next;
	logic [15:0] rd_data_reg, rd_data_next;
	logic done_reg, done_next;
	logic start_ok;

	op_state_t state_reg, state_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic [IDX_W-1:0] idx_reg, idx_next;
	flash_cmd_t cmd_reg, cmd_next;
	logic stall_reg, stall_next;
	logic finish, abort;
	logic busy;

	logic [23:0] latch_mem [ROW_WORDS];
	logic lat_we;
	logic [IDX_W-1:0] lat_idx;
	logic [23:0] lat_data;
	logic ack_reg, ack_next;
	logic [15:0] trd_reg, trd_next;
	logic pend1_reg, pend1_next;
	logic pend2_reg, pend2_next;
	logic [2:0] mode_reg, mode_next;

	assign busy = (state_reg != ST_IDLE);

	// ==========================================================
	// Register file
	always_comb begin
		ctrl_next = ctrl_reg;
		adrl_next = adrl_reg;
		adru_next = adru_reg;
		page_next = page_reg;
		key_next = key_reg;
		rd_data_next = 16'h0000;
		done_next = done_reg & ~i_done_clr;
		start_ok = 1'b0;
		if (i_wr_stb) begin
			// Any write other than the second key breaks the pair
			key_next = KEY_IDLE;
			case (i_addr)
				CTRL_ADDR: begin
					if (!busy) begin
						ctrl_next[PERMIT_BIT] = i_wr_data[PERMIT_BIT];
						ctrl_next[OP_MSB:0] = i_wr_data[OP_MSB:0];
						// Error bit can only be cleared by software
						ctrl_next[ERR_BIT] = ctrl_reg[ERR_BIT] & i_wr_data[ERR_BIT];
						if (i_wr_data[START_BIT] && key_reg == KEY_ARMED
								&& i_wr_data[PERMIT_BIT]
								&& op_valid(i_wr_data[OP_MSB:0])) begin
							ctrl_next[START_BIT] = 1'b1;
							start_ok = 1'b1;
						end
					end
				end
				ADRL_ADDR: begin
					adrl_next = i_wr_data;
				end
				ADRU_ADDR: begin
					adru_next = i_wr_data[7:0];
				end
				KEY_ADDR: begin
					if (i_wr_data[7:0] == KEY_FIRST) begin
						key_next = KEY_HALF;
					end else if (i_wr_data[7:0] == KEY_SECOND && key_reg == KEY_HALF) begin
						key_next = KEY_ARMED;
					end
				end
				PAGE_ADDR: begin
					page_next = i_wr_data[7:0];
				end
				default: begin
				end
			endcase
		end
		if (i_tbl.valid && !busy) begin
			adrl_next = i_tbl.ea;
			adru_next = page_reg;
		end
		// Completion and abort come after software so that a set wins
		if (finish) begin
			ctrl_next[START_BIT] = 1'b0;
			done_next = 1'b1;
		end
		if (abort) begin
			ctrl_next[START_BIT] = 1'b0;
			ctrl_next[ERR_BIT] = 1'b1;
		end
		if (i_rd_stb) begin
			case (i_addr)
				CTRL_ADDR: rd_data_next = ctrl_reg;
				ADRL_ADDR: rd_data_next = adrl_reg;
				ADRU_ADDR: rd_data_next = {8'h00, adru_reg};
				PAGE_ADDR: rd_data_next = {8'h00, page_reg};
				// Unlock register is write-only and reads zero
				default: rd_data_next = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_reg <= CTRL_RST;
			adrl_reg <= ADRL_RST;
			adru_reg <= BYTE_RST;
			page_reg <= BYTE_RST;
			key_reg <= KEY_IDLE;
			rd_data_reg <= 16'h0000;
			done_reg <= 1'b0;
		end else if (i_clk_en) begin
			ctrl_reg <= ctrl_next;
			adrl_reg <= adrl_next;
			adru_reg <= adru_next;
			page_reg <= page_next;
			key_reg <= key_next;
			rd_data_reg <= rd_data_next;
			done_reg <= done_next;
		end
	end

	// ==========================================================
	// Operation sequencer
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		idx_next = idx_reg;
		cmd_next = '0;
		finish = 1'b0;
		abort = 1'b0;
		unique case (state_reg)
			ST_IDLE: begin
				if (start_ok) begin
					cnt_next = '0;
					idx_next = '0;
					if (i_wr_data[OP_MSB:0] == OP_ERASE_ROW) begin
						// Erase clears the whole addressed row in one command
						cmd_next.erase = 1'b1;
						cmd_next.addr = row_base(adru_reg, adrl_reg);
						state_next = ST_WAIT;
					end else begin
						state_next = ST_PROG;
					end
				end
				if (i_tbl.valid && !i_tbl.write) begin
					cmd_next.rd = 1'b1;
					cmd_next.addr = {page_reg, i_tbl.ea[15:1], 1'b0};
				end
			end
			ST_PROG: begin
				// Stream the row latches into the array, one word a cycle
				cmd_next.prog = 1'b1;
				cmd_next.addr = row_base(adru_reg, adrl_reg) | {18'h00000, idx_reg, 1'b0};
				cmd_next.data = latch_mem[idx_reg];
				idx_next = idx_reg + 5'h01;
				cnt_next = cnt_reg + 19'h00001;
				if (idx_reg == IDX_LAST) begin
					state_next = ST_WAIT;
				end
			end
			ST_WAIT: begin
				cnt_next = cnt_reg + 19'h00001;
				if (cnt_reg == CNT_W'(OP_CYCLES_P - 1)) begin
					finish = 1'b1;
					state_next = ST_IDLE;
				end
			end
		endcase
		if (busy && (i_master_clear_pin_evt || i_wdt_evt)) begin
			// Address registers are left as they were
			abort = 1'b1;
			finish = 1'b0;
			state_next = ST_IDLE;
			cmd_next = '0;
		end
		stall_next = (state_next != ST_IDLE);
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= ST_IDLE;
			cnt_reg <= '0;
			idx_reg <= '0;
			cmd_reg <= '0;
			stall_reg <= 1'b0;
		end else if (i_clk_en) begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			idx_reg <= idx_next;
			cmd_reg <= cmd_next;
			stall_reg <= stall_next;
		end
	end

	// ==========================================================
	// Table access and write latches
	always_comb begin
		lat_we = 1'b0;
		lat_idx = i_tbl.ea[IDX_W:1];
		lat_data = latch_mem[lat_idx];
		ack_next = 1'b0;
		trd_next = 16'h0000;
		pend1_next = 1'b0;
		pend2_next = pend1_reg;
		mode_next = mode_reg;
		if (i_tbl.valid && !busy) begin
			if (i_tbl.write) begin
				// Latch only; the array is untouched until a program cycle
				lat_we = 1'b1;
				ack_next = 1'b1;
				if (i_tbl.high) begin
					// Odd byte of the high half is phantom and dropped
					if (!(i_tbl.byte_mode && i_tbl.ea[0])) begin
						lat_data[23:16] = i_tbl.wdata[7:0];
					end
				end else if (i_tbl.byte_mode) begin
					if (i_tbl.ea[0]) begin
						lat_data[15:8] = i_tbl.wdata[7:0];
					end else begin
						lat_data[7:0] = i_tbl.wdata[7:0];
					end
				end else begin
					lat_data[15:0] = i_tbl.wdata;
				end
			end else begin
				pend1_next = 1'b1;
				mode_next = {i_tbl.high, i_tbl.byte_mode, i_tbl.ea[0]};
			end
		end
		if (pend2_reg) begin
			ack_next = 1'b1;
			if (mode_reg[2]) begin
				trd_next = (mode_reg[1] && mode_reg[0]) ? 16'h0000
					: {8'h00, i_flash_rdata[23:16]};
			end else if (mode_reg[1]) begin
				trd_next = {8'h00, pick_byte(i_flash_rdata[15:0], mode_reg[0])};
			end else begin
				trd_next = i_flash_rdata[15:0];
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ack_reg <= 1'b0;
			trd_reg <= 16'h0000;
			pend1_reg <= 1'b0;
			pend2_reg <= 1'b0;
			mode_reg <= 3'h0;
		end else if (i_clk_en) begin
			ack_reg <= ack_next;
			trd_reg <= trd_next;
			pend1_reg <= pend1_next;
			pend2_reg <= pend2_next;
			mode_reg <= mode_next;
		end
	end

	// Latch contents need no reset; software fills them before use
	always_ff @(posedge i_clk) begin
		if (i_clk_en && lat_we) begin
			latch_mem[lat_idx] <= lat_data;
		end
	end

	// ==========================================================
	// Outputs
	assign o_rd_data = rd_data_reg;
	assign o_tbl_ack = ack_reg;
	assign o_tbl_rdata = trd_reg;
	assign o_flash = cmd_reg;
	assign o_done_flag = done_reg;
	assign o_cpu_stall = stall_reg;

endmodule // flash_self_program_ctrl

// ===== design/flash_self_program_pkg.sv
// Behaviour
// - Rows hold 32 words; panels hold 128 rows; erase clears one whole row.
// - Each panel has 32 words of write latches, filled before programming.
// - Table address is page register low byte above the 16-bit operand.
// - Low table accesses reach word bits 15..0, word or byte mode.
// - High table accesses reach word bits 23..16, word or byte mode.
// - Table writes update one latch in one cycle, never the array.
// - Latched data reach the array only through one program cycle per row.
// - Low address register captures operand bits 15..0 of each table access.
// - Upper address register captures bits 23..16 of each table access.
// - Software may write both address registers directly.
// - Unlock register is write-only; 0x55 then 0xAA arms one start.
// - CPU stalls for the whole operation, nominally 2 ms.
// - Control bit 15 starts the operation; hardware clears it at the end.
// - Software can set the start bit but never clear it.
// - Reset or watchdog abort sets the error flag; address stays.
// - Done flag sets on completion and stays until software clears it.
package flash_self_program_pkg;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned OP_TIME_US = 2000;
	localparam int unsigned OP_CYCLES = OP_TIME_US * CLK_MHZ;
	localparam int unsigned CNT_W = 19;

	// ==========================================================
	// Register map
	localparam logic [15:0] CTRL_ADDR = 16'h0760;
	localparam logic [15:0] ADRL_ADDR = 16'h0762;
	localparam logic [15:0] ADRU_ADDR = 16'h0764;
	localparam logic [15:0] KEY_ADDR = 16'h0766;
	localparam logic [15:0] PAGE_ADDR = 16'h0032;
	localparam int unsigned START_BIT = 15;
	localparam int unsigned PERMIT_BIT = 14;
	localparam int unsigned ERR_BIT = 13;
	localparam int unsigned OP_MSB = 6;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] ADRL_RST = 16'h0000;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [6:0] OP_ERASE_ROW = 7'h41;
	localparam logic [6:0] OP_PROG_ROW = 7'h01;
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;

	// ==========================================================
	// Array geometry
	localparam int unsigned ROW_WORDS = 32;
	localparam int unsigned ROWS_PER_PANEL = 128;
	localparam int unsigned IDX_W = 5;
	localparam logic [IDX_W-1:0] IDX_LAST = 5'h1f;
	localparam logic [15:0] ROW_MASK = 16'hffc0;

	typedef struct packed {
		logic valid;
		logic write;
		logic high;
		logic byte_mode;
		logic [15:0] ea;
		logic [15:0] wdata;
	} table_req_t;

	typedef struct packed {
		logic rd;
		logic erase;
		logic prog;
		logic [23:0] addr;
		logic [23:0] data;
	} flash_cmd_t;

	typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_WAIT} op_state_t;
	typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_ARMED} key_state_t;

	function automatic logic [23:0] row_base(input logic [7:0] up, input logic [15:0] lo);
		return {up, lo & ROW_MASK};
	endfunction

	function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic odd);
		return odd ? w[15:8] : w[7:0];
	endfunction

	function automatic logic op_valid(input logic [6:0] op);
		return (op == OP_ERASE_ROW) || (op == OP_PROG_ROW);
	endfunction

endpackage

// ===== dv/flash_ctrl_checker.sv
`timescale 1ns/1ns
module flash_ctrl_checker
	import flash_self_program_pkg::*;
#(
	parameter int unsigned OP_CYCLES_P = 40
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [15:0] i_addr,
	input wire logic [15:0] i_wr_data,
	input wire logic i_wr_stb,
	input wire logic i_rd_stb,
	input wire logic [15:0] o_rd_data,
	input wire table_req_t i_tbl,
	input wire logic o_tbl_ack,
	input wire flash_cmd_t o_flash,
	input wire logic i_master_clear_pin_evt,
	input wire logic i_wdt_evt,
	input wire logic o_done_flag,
	input wire logic o_cpu_stall
);
	// ==========
	// Helpers
	logic [18:0] cnt_reg;
	logic [18:0] cnt_next;
	logic key1;
	logic key2;
	assign key1 = i_wr_stb && i_addr == KEY_ADDR && i_wr_data[7:0] == KEY_FIRST;
	assign key2 = i_wr_stb && i_addr == KEY_ADDR && i_wr_data[7:0] == KEY_SECOND;
	always_comb cnt_next = o_cpu_stall ? cnt_reg + 19'h1 : 19'h0;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) cnt_reg <= 19'h0;
		else cnt_reg <= cnt_next;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// ==========
	// Checks
	a_key_unread: assert property ($past(i_rd_stb && i_addr == KEY_ADDR) |-> o_rd_data == 16'h0)
		else $error("key readable");
	a_start_keyed: assert property ($rose(o_cpu_stall) |-> $past(key1, 3) && $past(key2, 2)
		&& $past(i_wr_stb && i_addr == CTRL_ADDR && i_wr_data[15:14] == 2'h3)) else $error("bad start");
	a_op_kind: assert property ($rose(o_cpu_stall) |-> !o_flash.prog
		&& o_flash.erase == ($past(i_wr_data[6:0]) == OP_ERASE_ROW)
		##1 o_flash.prog != $past(o_flash.erase)) else $error("op kind");
	a_prog_order: assert property (o_flash.prog && o_flash.addr[5:1] != IDX_LAST |=>
		o_flash.prog && o_flash.addr == $past(o_flash.addr) + 24'h2) else $error("prog order");
	a_array_busy: assert property (o_flash.prog || o_flash.erase |-> o_cpu_stall)
		else $error("array idle");
	a_stall_span: assert property ($fell(o_cpu_stall) && !$past(i_master_clear_pin_evt || i_wdt_evt) |->
		cnt_reg == OP_CYCLES_P && o_done_flag) else $error("stall span");
	a_abort_stop: assert property (o_cpu_stall && (i_master_clear_pin_evt || i_wdt_evt) |=>
		!o_cpu_stall && !$rose(o_done_flag)) else $error("abort");
	a_tbl_rd_path: assert property (i_tbl.valid && !i_tbl.write && !o_cpu_stall |=> o_flash.rd
		&& o_flash.addr[15:1] == $past(i_tbl.ea[15:1]) ##2 o_tbl_ack) else $error("tbl read");
endmodule // flash_ctrl_checker

bind flash_self_program_ctrl flash_ctrl_checker #(.OP_CYCLES_P(OP_CYCLES_P)) flash_ctrl_checker_i (.*);

// ===== dv/flash_macro_model.sv
`timescale 1ns/1ns
module flash_macro_model
	import flash_self_program_pkg::*;
(
	input wire logic i_clk,
	input wire flash_cmd_t i_cmd,
	output logic [23:0] o_rdata
);
	// ==========
	// Array
	logic [23:0] mem [int];
	initial o_rdata = 24'h0;
	// Data toggles outside the read slot so stale values never match
	always @(posedge i_clk) begin
		o_rdata <= ~o_rdata;
		if (i_cmd.prog) mem[i_cmd.addr] = i_cmd.data;
		if (i_cmd.erase) for (int i = 0; i < 64; i += 2) mem[i_cmd.addr + i] = 24'hffffff;
		if (i_cmd.rd) o_rdata <= mem.exists(i_cmd.addr) ? mem[i_cmd.addr] : 24'hffffff;
	end
endmodule // flash_macro_model

// ===== dv/testbench.sv
`timescale 1ns/1ns
module testbench;
	import flash_self_program_pkg::*;
	localparam int unsigned OPC = 40;
	logic i_clk = 0;
	logic i_rst_n = 0;
	logic i_clk_en = 1;
	logic i_wr_stb = 0;
	logic i_rd_stb = 0;
	logic i_master_clear_pin_evt = 0;
	logic i_wdt_evt = 0;
	logic i_done_clr = 0;
	logic [15:0] i_addr = 16'h0;
	logic [15:0] i_wr_data = 16'h0;
	logic [15:0] o_rd_data;
	logic [15:0] o_tbl_rdata;
	table_req_t i_tbl = '0;
	flash_cmd_t o_flash;
	logic [23:0] i_flash_rdata;
	logic o_tbl_ack;
	logic o_done_flag;
	logic o_cpu_stall;
	int errors = 0;
	int tests_run = 0;
	always #2 i_clk = ~i_clk;
	flash_self_program_ctrl #(.OP_CYCLES_P(OPC)) flash_self_program_ctrl_i (.i_clk(i_clk),
		.i_rst_n(i_rst_n), .i_clk_en(i_clk_en), .i_addr(i_addr), .i_wr_data(i_wr_data),
		.i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data), .i_tbl(i_tbl),
		.o_tbl_ack(o_tbl_ack), .o_tbl_rdata(o_tbl_rdata), .o_flash(o_flash),
		.i_flash_rdata(i_flash_rdata), .i_master_clear_pin_evt(i_master_clear_pin_evt), .i_wdt_evt(i_wdt_evt),
		.i_done_clr(i_done_clr), .o_done_flag(o_done_flag), .o_cpu_stall(o_cpu_stall));
	flash_macro_model flash_macro_model_i (.i_clk(i_clk), .i_cmd(o_flash), .o_rdata(i_flash_rdata));
	// ==========
	// Bus tasks
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic idle();
		@(posedge i_clk);
		i_wr_stb <= 0;
		i_rd_stb <= 0;
		i_tbl.valid <= 0;
		#1;
	endtask
	task automatic wr(logic [15:0] a, logic [15:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wr_data <= d;
		i_wr_stb <= 1;
	endtask
	task automatic rd(logic [15:0] a, output logic [15:0] q);
		@(posedge i_clk);
		i_addr <= a;
		i_wr_stb <= 0;
		i_rd_stb <= 1;
		idle();
		q = o_rd_data;
	endtask
	task automatic start(logic [15:0] v);
		wr(KEY_ADDR, 16'h0055);
		wr(KEY_ADDR, 16'h00aa);
		wr(CTRL_ADDR, v);
		idle();
	endtask
	task automatic tbl(logic w, logic h, logic [15:0] ea, logic [15:0] d, output logic [15:0] q,
			input logic b = 1'b0);
		@(posedge i_clk);
		i_tbl <= '{1'b1, w, h, b, ea, d};
		idle();
		for (int n = 0; n < 4 && o_tbl_ack !== 1'b1; n++) idle();
		chk("tbl_ack", o_tbl_ack, 1);
		q = o_tbl_rdata;
	endtask
	task automatic wait_idle();
		for (int n = 0; n < OPC + 8 && o_cpu_stall !== 1'b0; n++) idle();
	endtask
	// ==========
	// Scenarios
	task automatic t_prog();
		logic [15:0] q;
		wr(PAGE_ADDR, 16'h0001);
		idle();
		for (int i = 0; i < 32; i++) begin
			tbl(1, 0, 16'h0040 + 16'(2 * i), 16'ha500 ^ 16'(i), q);
			tbl(1, 1, 16'h0040 + 16'(2 * i), 16'h0030 + 16'(i), q);
		end
		rd(ADRL_ADDR, q);
		chk("adrl", q, 16'h007e);
		rd(ADRU_ADDR, q);
		chk("adru", q, 16'h0001);
		start(16'hc001);
		// First program word leaves one cycle after the start is taken
		idle();
		for (int i = 0; i < 32; i++) begin
			chk("prog_addr", {o_flash.prog, o_flash.addr}, {1'b1, 24'h010040 + 24'(2 * i)});
			chk("prog_data", o_flash.data, {8'h30 + 8'(i), 16'ha500 ^ 16'(i)});
			idle();
		end
		wait_idle();
		rd(CTRL_ADDR, q);
		chk("ctrl_done", {o_done_flag, q}, {1'b1, 16'h4001});
		tbl(0, 0, 16'h0042, 16'h0, q);
		chk("rd_low", q, 16'ha501);
		tbl(0, 1, 16'h0042, 16'h0, q);
		chk("rd_high", q, 16'h0031);
		tbl(0, 0, 16'h0043, 16'h0, q, 1'b1);
		chk("rd_byte", q, 16'h00a5);
		tbl(0, 1, 16'h0043, 16'h0, q, 1'b1);
		chk("rd_phantom", q, 16'h0000);
	endtask
	task automatic t_erase();
		logic [15:0] q;
		wr(ADRU_ADDR, 16'h0001);
		wr(ADRL_ADDR, 16'h0046);
		start(16'hc041);
		chk("erase", {o_cpu_stall, o_flash.erase, o_flash.addr}, {2'h3, 24'h010040});
		wait_idle();
		tbl(0, 0, 16'h005e, 16'h0, q);
		chk("erased", q, 16'hffff);
	endtask
	task automatic t_refuse();
		logic [15:0] q;
		wr(KEY_ADDR, 16'h0055);
		wr(ADRL_ADDR, 16'h0046);
		wr(KEY_ADDR, 16'h00aa);
		wr(CTRL_ADDR, 16'hc041);
		idle();
		chk("broken_key", o_cpu_stall, 0);
		start(16'h8041);
		chk("no_permit", o_cpu_stall, 0);
		rd(KEY_ADDR, q);
		chk("key_read", q, 16'h0);
		wr(ADRL_ADDR, 16'h1234);
		i_clk_en <= 0;
		@(posedge i_clk);
		i_wr_stb <= 0;
		i_clk_en <= 1;
		rd(ADRL_ADDR, q);
		chk("frozen", q, 16'h0046);
	endtask
	task automatic t_abort();
		logic [15:0] q;
		for (int k = 0; k < 2; k++) begin
			@(posedge i_clk);
			i_done_clr <= 1;
			@(posedge i_clk);
			i_done_clr <= 0;
			start(16'hc041);
			repeat (2) idle();
			@(posedge i_clk);
			{i_wdt_evt, i_master_clear_pin_evt} <= 2'(k + 1);
			@(posedge i_clk);
			i_master_clear_pin_evt <= 0;
			i_wdt_evt <= 0;
			#1;
			chk("abort", {o_cpu_stall, o_done_flag}, 0);
			rd(CTRL_ADDR, q);
			chk("err_bit", q, 16'h6041);
			rd(ADRL_ADDR, q);
			chk("adrl_kept", q, 16'h0046);
		end
	endtask
	task automatic give_verdict();
		if (errors == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge i_clk);
		i_rst_n <= 1;
		t_prog();
		t_erase();
		t_refuse();
		t_abort();
		give_verdict();
	end
	// Whole run is under a thousand cycles; ten times that means a hang
	initial begin
		#40000;
		errors++;
		give_verdict();
	end
endmodule // testbench
